// >>> src/qdl_pkg.sv
// Constants shared by the quad converter serial load logic.
// Assumes a host drives frame select, serial clock and data; all control pins are plain ports.
//
// Summary of operation
// - Each command is a 16-bit word shifted in most significant bit first.
// - Word bits 15 and 14 pick channel A, B, C or D.
// - Bit 13 sets channel range: 0 one times, 1 twice reference.
// - Bit 12 sets reference mode: 0 unbuffered, 1 buffered.
// - Code follows control bits, straight binary; narrower variants drop low bits.
// - Active-low frame select gates the link; data taken only while low.
// - While framed, data shifts on each serial clock falling edge, 16 pulses.
// - Standalone mode ignores clocks after the 16th edge until reframed.
// - A finished word is copied into the addressed channel's input register.
// - Frame rising before the 16th edge aborts; input registers unchanged.
// - Clear input forces all input and output registers to zero.
// - After power-up all registers zero, unbuffered reference, one times range.
// - Serial stage wakes on frame fall, sleeps on frame rise.
// - Chain mode removes 16-pulse gating; every framed pulse shifts.
// - Chain mode shifts overflow bits out, launched rising, valid falling.
// - Load high holds outputs; load low passes input registers through.
// - An output updates only if its input register was written since.
// - With load low, outputs update right after a completed word.
// - Range and reference bits are double buffered with the code.
// - Sleep keeps contents and still accepts register writes.
package qdl_pkg;

	// ****************************************************************
	// Word layout
	// ****************************************************************
	localparam int          WORD_BITS      = 16;
	localparam int          CHANNELS       = 4;
	localparam int          CH_MSB_POS     = 15;
	localparam int          CH_LSB_POS     = 14;
	localparam int          RANGE_POS      = 13;
	localparam int          REFBUF_POS     = 12;
	localparam int          CODE_MSB_POS   = 11;
	localparam int          CODE_FULL_BITS = 12;

	// ****************************************************************
	// Reset values and counts
	// ****************************************************************
	localparam logic        RANGE_RESET    = 1'b0;
	localparam logic        REFBUF_RESET   = 1'b0;
	localparam logic [4:0]  COUNT_RESET    = 5'h00;
	localparam logic [4:0]  COUNT_LAST     = 5'h0F;
	localparam logic [4:0]  COUNT_DONE     = 5'h10;
	localparam logic [4:0]  PIN_RESET      = 5'h17;

endpackage : qdl_pkg

// >>> src/qdl_sync.sv
// Two-flop level synchroniser, one bit per lane.
// Assumes inputs are levels from another clock domain or from pins.
module qdl_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// Lanes
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// ****************************************************************
	// Two stages; first stage read only by second
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q   <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : qdl_sync

// >>> src/qdl_serial_load.sv
// Serial load logic of a quad voltage-output converter.
// Assumes link_sclk is the host's burst clock, frame_sel_n idles high,
// and the control pins are asynchronous to clock.
module qdl_serial_load #(
	parameter int CODE_BITS = qdl_pkg::CODE_FULL_BITS
) (
	// System clock and reset
	input  wire logic                                     clock,
	input  wire logic                                     rst,
	// Serial link
	input  wire logic                                     link_sclk,
	input  wire logic                                     frame_sel_n,
	input  wire logic                                     serial_din,
	output logic                                          chain_data_out,
	// Control pins
	input  wire logic                                     chain_enable,
	input  wire logic                                     load_outputs_n,
	input  wire logic                                     clear_all_n,
	input  wire logic                                     sleep_n,
	// Converter side
	output logic [qdl_pkg::CHANNELS-1:0][CODE_BITS-1:0]   dac_code,
	output logic [qdl_pkg::CHANNELS-1:0]                  dac_range,
	output logic [qdl_pkg::CHANNELS-1:0]                  dac_refbuf,
	output logic [qdl_pkg::CHANNELS-1:0]                  update_pending,
	output logic                                          outputs_powered,
	output logic                                          serial_stage_awake
);

	// ****************************************************************
	// Link domain signals
	// ****************************************************************
	logic [qdl_pkg::WORD_BITS-1:0] shift_q;
	logic [qdl_pkg::WORD_BITS-1:0] shift_d;
	logic [qdl_pkg::WORD_BITS-1:0] word_q;
	logic [4:0]                    count_q;
	logic                          done_tgl_q;
	logic                          whole_q;
	logic                          chain_meta_q;
	logic                          chain_link_q;
	logic                          chain_out_q;
	logic                          shift_en;
	logic                          word_done;

	// ****************************************************************
	// System domain signals
	// ****************************************************************
	logic [4:0]                    pins_s;
	logic                          frame_s;
	logic                          chain_s;
	logic                          load_s;
	logic                          clear_s;
	logic                          sleep_s;
	logic                          frame_prev_q;
	logic                          done_tgl_s;
	logic                          done_prev_q;
	logic                          whole_s;
	logic                          sa_commit;
	logic                          chain_commit;
	logic                          wr_en;
	logic [qdl_pkg::WORD_BITS-1:0] wr_word;
	logic [1:0]                    wr_ch;
	logic                          wr_range;
	logic                          wr_refbuf;
	logic [qdl_pkg::CHANNELS-1:0][CODE_BITS-1:0] in_code_q;
	logic [qdl_pkg::CHANNELS-1:0]  in_range_q;
	logic [qdl_pkg::CHANNELS-1:0]  in_refbuf_q;
	logic [qdl_pkg::CHANNELS-1:0]  pending_q;
	logic [qdl_pkg::CHANNELS-1:0][CODE_BITS-1:0] out_code_q;
	logic [qdl_pkg::CHANNELS-1:0]  out_range_q;
	logic [qdl_pkg::CHANNELS-1:0]  out_refbuf_q;

	// Code field of a word, narrowed to the variant width
	function automatic logic [CODE_BITS-1:0] code_of(input logic [qdl_pkg::WORD_BITS-1:0] w);
		code_of = w[qdl_pkg::CODE_MSB_POS -: CODE_BITS];
	endfunction : code_of

	// Last edge of a 16-pulse word within the frame
	function automatic logic word_edge(input logic [4:0] cnt);
		word_edge = (5'(cnt[3:0]) == qdl_pkg::COUNT_LAST);
	endfunction : word_edge

	// ****************************************************************
	// Link domain: chain mode strap on the serial clock
	// ****************************************************************

	// Two flops before the link logic reads the strap
	always_ff @(negedge link_sclk or posedge rst) begin
		if (rst) begin
			chain_meta_q <= 1'b0;
			chain_link_q <= 1'b0;
		end else begin
			chain_meta_q <= chain_enable;
			chain_link_q <= chain_meta_q;
		end
	end

	// ****************************************************************
	// Link domain: shifting and pulse counting
	// ****************************************************************

	// Gating stops after 16 pulses unless chained
	assign shift_en = chain_link_q || (count_q < qdl_pkg::COUNT_DONE);
	assign shift_d  = {shift_q[qdl_pkg::WORD_BITS-2:0], serial_din};
	assign word_done = !frame_sel_n && !chain_link_q && (count_q == qdl_pkg::COUNT_LAST);

	// Shift register keeps its contents across frames
	always_ff @(negedge link_sclk) begin
		if (!frame_sel_n && shift_en) begin
			shift_q <= shift_d;
		end
	end

	// Pulse counter cleared by the frame itself going high
	always_ff @(negedge link_sclk or posedge frame_sel_n or posedge rst) begin
		if (rst || frame_sel_n) begin
			count_q <= qdl_pkg::COUNT_RESET;
		end else if (chain_link_q) begin
			count_q <= word_edge(count_q) ? qdl_pkg::COUNT_RESET : count_q + 5'h01;
		end else if (count_q < qdl_pkg::COUNT_DONE) begin
			count_q <= count_q + 5'h01;
		end
	end

	// Completion toggle at the 16th edge of a standalone word
	always_ff @(negedge link_sclk or posedge rst) begin
		if (rst) begin
			done_tgl_q <= 1'b0;
		end else if (word_done) begin
			done_tgl_q <= ~done_tgl_q;
		end
	end

	// Word held steady for the system domain until the next word
	always_ff @(negedge link_sclk or posedge rst) begin
		if (rst) begin
			word_q <= '0;
		end else if (word_done) begin
			word_q <= shift_d;
		end
	end

	// Chain mode: marks a whole number of words shifted this frame
	always_ff @(negedge link_sclk or posedge rst) begin
		if (rst) begin
			whole_q <= 1'b0;
		end else if (!frame_sel_n) begin
			whole_q <= chain_link_q && word_edge(count_q);
		end
	end

	// Overflow bit launched on the rising edge
	always_ff @(posedge link_sclk or posedge frame_sel_n or posedge rst) begin
		if (rst || frame_sel_n) begin
			chain_out_q <= 1'b0;
		end else if (chain_link_q) begin
			chain_out_q <= shift_q[qdl_pkg::WORD_BITS-1];
		end
	end

	assign chain_data_out = chain_out_q;

	// ****************************************************************
	// System domain: pin and event synchronisers
	// ****************************************************************

	// Frame, chain, load, clear, sleep
	qdl_sync #(
		.WIDTH     (5),
		.RESET_VAL (qdl_pkg::PIN_RESET)
	) u_pin_sync (
		.clock    (clock),
		.rst      (rst),
		.async_in ({frame_sel_n, chain_enable, load_outputs_n, clear_all_n, sleep_n}),
		.sync_out (pins_s)
	);

	// Standalone completion toggle
	qdl_sync #(
		.WIDTH     (1),
		.RESET_VAL (1'b0)
	) u_done_sync (
		.clock    (clock),
		.rst      (rst),
		.async_in (done_tgl_q),
		.sync_out (done_tgl_s)
	);

	// Whole-word marker; same depth as frame, settled before frame rises
	qdl_sync #(
		.WIDTH     (1),
		.RESET_VAL (1'b0)
	) u_whole_sync (
		.clock    (clock),
		.rst      (rst),
		.async_in (whole_q),
		.sync_out (whole_s)
	);

	// Decoded synchronised levels
	assign frame_s = pins_s[4];
	assign chain_s = pins_s[3];
	assign load_s  = ~pins_s[2];
	assign clear_s = ~pins_s[1];
	assign sleep_s = ~pins_s[0];

	// Frame history; idles high so no false rise after reset
	always_ff @(posedge clock) begin
		if (rst) begin
			frame_prev_q <= 1'b1;
		end else begin
			frame_prev_q <= frame_s;
		end
	end

	// Toggle history for completion detection
	always_ff @(posedge clock) begin
		if (rst) begin
			done_prev_q <= 1'b0;
		end else begin
			done_prev_q <= done_tgl_s;
		end
	end

	// ****************************************************************
	// System domain: write decode
	// ****************************************************************

	// Standalone word on toggle, chain word on frame rise
	assign sa_commit    = done_tgl_s ^ done_prev_q;
	assign chain_commit = frame_s && !frame_prev_q && chain_s && whole_s;
	assign wr_en        = sa_commit || chain_commit;
	assign wr_word      = sa_commit ? word_q : shift_q;
	assign wr_ch        = {wr_word[qdl_pkg::CH_MSB_POS], wr_word[qdl_pkg::CH_LSB_POS]};
	assign wr_range     = wr_word[qdl_pkg::RANGE_POS];
	assign wr_refbuf    = wr_word[qdl_pkg::REFBUF_POS];

	// ****************************************************************
	// System domain: input registers
	// ****************************************************************

	// Input codes, written regardless of sleep
	always_ff @(posedge clock) begin
		if (rst || clear_s) begin
			in_code_q <= '0;
		end else if (wr_en) begin
			in_code_q[wr_ch] <= code_of(wr_word);
		end
	end

	// Input range bits
	always_ff @(posedge clock) begin
		if (rst || clear_s) begin
			in_range_q <= {qdl_pkg::CHANNELS{qdl_pkg::RANGE_RESET}};
		end else if (wr_en) begin
			in_range_q[wr_ch] <= wr_range;
		end
	end

	// Input reference mode bits
	always_ff @(posedge clock) begin
		if (rst || clear_s) begin
			in_refbuf_q <= {qdl_pkg::CHANNELS{qdl_pkg::REFBUF_RESET}};
		end else if (wr_en) begin
			in_refbuf_q[wr_ch] <= wr_refbuf;
		end
	end

	// Written-since-update flags; a write beats a load
	always_ff @(posedge clock) begin
		if (rst || clear_s) begin
			pending_q <= '0;
		end else begin
			for (int ch = 0; ch < qdl_pkg::CHANNELS; ch++) begin
				if (wr_en && wr_ch == ch[1:0]) begin
					pending_q[ch] <= 1'b1;
				end else if (load_s) begin
					pending_q[ch] <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// System domain: output registers
	// ****************************************************************

	// Output codes, transparent while load is low, written channels only
	always_ff @(posedge clock) begin
		if (rst || clear_s) begin
			out_code_q <= '0;
		end else if (load_s) begin
			for (int ch = 0; ch < qdl_pkg::CHANNELS; ch++) begin
				if (pending_q[ch]) begin
					out_code_q[ch] <= in_code_q[ch];
				end
			end
		end
	end

	// Output range bits, buffered with the code
	always_ff @(posedge clock) begin
		if (rst || clear_s) begin
			out_range_q <= {qdl_pkg::CHANNELS{qdl_pkg::RANGE_RESET}};
		end else if (load_s) begin
			for (int ch = 0; ch < qdl_pkg::CHANNELS; ch++) begin
				if (pending_q[ch]) begin
					out_range_q[ch] <= in_range_q[ch];
				end
			end
		end
	end

	// Output reference mode bits, buffered with the code
	always_ff @(posedge clock) begin
		if (rst || clear_s) begin
			out_refbuf_q <= {qdl_pkg::CHANNELS{qdl_pkg::REFBUF_RESET}};
		end else if (load_s) begin
			for (int ch = 0; ch < qdl_pkg::CHANNELS; ch++) begin
				if (pending_q[ch]) begin
					out_refbuf_q[ch] <= in_refbuf_q[ch];
				end
			end
		end
	end

	// ****************************************************************
	// Status and converter outputs
	// ****************************************************************

	// Serial stage awake while framed
	always_ff @(posedge clock) begin
		if (rst) begin
			serial_stage_awake <= 1'b0;
		end else begin
			serial_stage_awake <= ~frame_s;
		end
	end

	// Power state; registers stay writable while asleep
	always_ff @(posedge clock) begin
		if (rst) begin
			outputs_powered <= 1'b0;
		end else begin
			outputs_powered <= ~sleep_s;
		end
	end

	// Converter side views of the output bank
	assign dac_code       = out_code_q;
	assign dac_range      = out_range_q;
	assign dac_refbuf     = out_refbuf_q;
	assign update_pending = pending_q;

endmodule : qdl_serial_load

// >>> verification/qdl_serial_load_checker.sv
// Concurrent checks on the serial load logic, seen from its ports only.
// Assumes the clock domain of clock with rst as synchronous reset.
module qdl_serial_load_checker #(
	parameter int CODE_BITS = qdl_pkg::CODE_FULL_BITS
) (
	// Clock and reset
	input wire logic                                   clock,
	input wire logic                                   rst,
	// Pins
	input wire logic                                   frame_sel_n,
	input wire logic                                   chain_data_out,
	input wire logic                                   load_outputs_n,
	input wire logic                                   clear_all_n,
	input wire logic                                   sleep_n,
	// Converter side
	input wire logic [qdl_pkg::CHANNELS-1:0][CODE_BITS-1:0] dac_code,
	input wire logic [qdl_pkg::CHANNELS-1:0]           dac_range,
	input wire logic [qdl_pkg::CHANNELS-1:0]           dac_refbuf,
	input wire logic [qdl_pkg::CHANNELS-1:0]           update_pending,
	input wire logic                                   outputs_powered,
	input wire logic                                   serial_stage_awake
);
	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	reset_zero_a: assert property (disable iff (1'b0) rst |=> dac_code == '0 && dac_range == '0
		&& dac_refbuf == '0 && update_pending == '0 && !outputs_powered) else $error("outputs not zero after reset");
	clear_zero_a: assert property (!clear_all_n [*4] |-> dac_code == '0 && dac_range == '0
		&& dac_refbuf == '0 && update_pending == '0) else $error("clear did not zero registers");
	hold_outputs_a: assert property ((load_outputs_n && clear_all_n) [*4] |-> $stable(dac_code)
		&& $stable(dac_range) && $stable(dac_refbuf)) else $error("outputs moved while load high");
	pending_load_a: assert property ((!load_outputs_n && clear_all_n) [*4] ##0 (update_pending != '0)
		|=> (update_pending & $past(update_pending)) == '0) else $error("pending channel not loaded");
	unwritten_hold_a: assert property (clear_all_n [*4] ##0 !update_pending[0]
		|=> $stable(dac_code[0])) else $error("unwritten channel updated");
	powered_on_a: assert property (sleep_n [*4] |-> outputs_powered) else $error("powered flag low");
	asleep_flag_a: assert property (!sleep_n [*4] |-> !outputs_powered) else $error("powered flag high");
	stage_awake_a: assert property ($stable(frame_sel_n) [*4] |-> serial_stage_awake == !frame_sel_n)
		else $error("serial stage state wrong");
	chain_idle_a: assert property (frame_sel_n |-> !chain_data_out) else $error("chain output active");
endmodule : qdl_serial_load_checker

bind qdl_serial_load qdl_serial_load_checker #(.CODE_BITS(CODE_BITS)) qdl_serial_load_checker_i (.clock, .rst,
	.frame_sel_n, .chain_data_out, .load_outputs_n, .clear_all_n, .sleep_n, .dac_code, .dac_range,
	.dac_refbuf, .update_pending, .outputs_powered, .serial_stage_awake);

// >>> verification/qdl_host_model.sv
// Host serial port model: frame select, burst clock and data, MSB first.
// Assumes the bench calls frame() and waits for it to return.
module qdl_host_model (
	// Link to the device
	output logic        link_sclk,
	output logic        frame_sel_n,
	output logic        serial_din,
	input  wire logic   chain_data_out,
	// Bits seen on the chain output
	output logic [15:0] echo
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle link: clock still high, frame high
	initial begin
		link_sclk = 1'b1;
		frame_sel_n = 1'b1;
		serial_din = 1'b0;
		echo = 16'h0000;
	end

	// One frame of n pulses, 64 ns period
	task automatic frame(input logic [31:0] bits, input int n);
		#7 frame_sel_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_din = bits[i];
			#32 echo = {echo[14:0], chain_data_out};
			link_sclk = 1'b0;
			#32 link_sclk = 1'b1;
		end
		#20 frame_sel_n = 1'b1;
		serial_din = ~serial_din;
	endtask : frame
endmodule : qdl_host_model

// >>> verification/qdl_serial_load_tb_top.sv
// Self-checking bench for the serial load logic.
// Assumes the host model drives the link and the default 12-bit code.
module qdl_serial_load_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      clock, rst, link_sclk, frame_sel_n, serial_din, chain_data_out;
	logic                      chain_enable, load_outputs_n, clear_all_n, sleep_n;
	logic [3:0][11:0]          dac_code;
	logic [3:0]                dac_range, dac_refbuf, update_pending;
	logic                      outputs_powered, serial_stage_awake;
	logic [15:0]               echo, w;
	int                        fails, cmp_count;

	// Device and host
	qdl_serial_load #(.CODE_BITS(12)) qdl_serial_load_i (.clock, .rst, .link_sclk, .frame_sel_n, .serial_din,
		.chain_data_out, .chain_enable, .load_outputs_n, .clear_all_n, .sleep_n, .dac_code, .dac_range,
		.dac_refbuf, .update_pending, .outputs_powered, .serial_stage_awake);
	qdl_host_model qdl_host_model_i (.link_sclk, .frame_sel_n, .serial_din, .chain_data_out, .echo);

	// 25 MHz clock
	always #20 clock = ~clock;

	// Compare after the edge's updates land
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		#1;
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One frame, then the fixed commit and load latency
	task automatic wr(input logic [31:0] bits, input int n);
		qdl_host_model_i.frame(bits, n);
		repeat (10) @(posedge clock);
	endtask : wr

	// Verdict
	task automatic wrap_up();
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// Main sequence
	initial begin
		clock = 1'b0;
		rst = 1'b0;
		chain_enable = 1'b0;
		load_outputs_n = 1'b1;
		clear_all_n = 1'b1;
		sleep_n = 1'b1;
		fails = 0;
		cmp_count = 0;
		@(posedge clock);
		rst <= 1'b1;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		chk("code", 16'h0000, 16'(dac_code));
		chk("flags", 16'h0000, {8'h00, dac_range, dac_refbuf});
		wr(32'h0000_7ABC, 16);
		chk("pending", 16'h0002, 16'(update_pending));
		chk("held B", 16'h0000, 16'(dac_code[1]));
		load_outputs_n <= 1'b0;
		repeat (5) @(posedge clock);
		chk("code B", 16'h0ABC, 16'(dac_code[1]));
		chk("flags B", 16'h0022, {8'h00, dac_range, dac_refbuf});
		chk("pending", 16'h0000, 16'(update_pending));
		for (int c = 0; c < 4; c++) begin
			w = {c[1:0], c[0], c[1], 12'(16'h0111 * (c + 1))};
			wr({16'h0000, w}, 16);
			chk("code", {4'h0, w[11:0]}, 16'(dac_code[c]));
			chk("range", 16'(c[0]), 16'(dac_range[c]));
		end
		wr(32'h0000_03FF, 10);
		chk("abort D", 16'h0444, 16'(dac_code[3]));
		wr(32'h0000_5A5F, 20);
		chk("extra bits", 16'h05A5, 16'(dac_code[0]));
		sleep_n <= 1'b0;
		wr(32'h0000_8123, 16);
		chk("sleep write", 16'h0123, 16'(dac_code[2]));
		chk("powered", 16'h0000, 16'(outputs_powered));
		sleep_n <= 1'b1;
		clear_all_n <= 1'b0;
		repeat (5) @(posedge clock);
		chk("cleared", 16'h0000, 16'(dac_code[3]));
		clear_all_n <= 1'b1;
		chain_enable <= 1'b1;
		wr(32'h0000_0000, 2);
		wr(32'h4F0F_C0F0, 32);
		chk("chain word", 16'h00F0, 16'(dac_code[3]));
		chk("first word", 16'h0000, 16'(dac_code[1]));
		chk("chain out", 16'h4F0F, echo);
		wrap_up();
	end
endmodule : qdl_serial_load_tb_top
